// ==== src/sswt_pkg.sv ====
// Constants, codes and register map of the scan sweep trigger sequencer
package sswt_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;           // System clock period
    localparam int US_NS         = 1000;         // One microsecond in ns
    localparam int MS_US         = 1000;         // One millisecond in us
    localparam int CYC_PER_US    = US_NS / CLK_PERIOD_NS;
    localparam int CYC_PER_MS    = MS_US * CYC_PER_US;
    localparam int LONG_PRESS_MS = 2000;         // Key hold that ends an unlimited course
    localparam int LONG_PRESS_CYC = LONG_PRESS_MS * CYC_PER_MS;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_INTERVAL = 8'h04;
    localparam logic [7:0] ADDR_SWEEPS   = 8'h08;
    localparam logic [7:0] ADDR_STATUS   = 8'h0C;
    localparam logic [7:0] ADDR_COUNT    = 8'h10;

    // ------------------------------------------------------------
    // Control field positions
    // ------------------------------------------------------------
    localparam int CTRL_SEL_LSB = 0;             // sweep_trigger_select [2:0]
    localparam int CTRL_EXT_POL = 3;             // external_trigger_polarity
    localparam int CTRL_OUT_POL = 4;             // Signal output polarity
    localparam int CTRL_UNLIM   = 5;             // unlimited_sweeps
    localparam int CTRL_ALM_LSB = 6;             // Alarm number select [7:6]
    localparam int CTRL_START   = 8;             // Write 1: start a course
    localparam int CTRL_STOP    = 9;             // Write 1: abort a course

    // Status field positions
    localparam int STAT_ACTIVE = 0;
    localparam int STAT_WAIT   = 1;
    localparam int STAT_SWEEP  = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] INTERVAL_RST = 32'h000F_4240;  // 1 s in us
    localparam logic [15:0] SWEEPS_RST   = 16'h0001;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        TRIG_AUTO     = 3'h0,
        TRIG_TIMER    = 3'h1,
        TRIG_MANUAL   = 3'h2,
        TRIG_EXTERNAL = 3'h3,
        TRIG_ALARM    = 3'h4
    } sswt_trig_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_WAIT  = 3'b010,
        ST_SWEEP = 3'b100
    } sswt_state_t;

endpackage

// ==== src/sswt_edge.sv ====
// Polarity-selectable edge detector for one trigger line
`timescale 1ns/1ps
`default_nettype none

module sswt_edge (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // Line in
    input  wire logic level,
    input  wire logic invert,
    // Active edge pulse
    output logic      pulse
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic prev;                              // Active level last cycle
    } sswt_edge_st_t;

    sswt_edge_st_t st;                           // Registered state
    sswt_edge_st_t next_st;                      // Next state
    logic          active;                       // Level in active sense

    // Fold polarity in, then look for the inactive-to-active step
    always_comb begin
        active       = level ^ invert;
        next_st.prev = active;
        pulse        = active & ~st.prev;
    end

    // Reset high so an already active line gives no false edge
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st.prev <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

endmodule

`default_nettype wire

// ==== src/sswt_top.sv ====
// Scan sweep trigger sequencer with AXI4-Lite register access
//
// The register offsets and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module sswt_top
    import sswt_pkg::*;
#(
    parameter int LONG_PRESS_CYCLES = sswt_pkg::LONG_PRESS_CYC
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        nrst,
    // AXI4-Lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Operator and rear panel
    input  wire logic        scan_key,
    input  wire logic        ext_trigger,
    output logic             signal_out,
    // Measurement machinery
    input  wire logic [3:0]  alarm_hit,
    input  wire logic        sweep_done,
    output logic             sweep_start,
    output logic             course_active
);

    import sswt_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    typedef struct packed {
        sswt_state_t state;                      // Sequencer state
        logic        aw_have;                    // Write address held
        logic [7:0]  aw_addr;                    // Held write address
        logic        w_have;                     // Write data held
        logic [31:0] w_data;                     // Held write data
        logic [3:0]  w_strb;                     // Held byte strobes
        logic        bvalid;                     // Write response pending
        logic [1:0]  bresp;                      // Write response code
        logic        rvalid;                     // Read data pending
        logic [31:0] rdata;                      // Read data
        logic [1:0]  rresp;                      // Read response code
        logic [2:0]  trig_sel;                   // sweep_trigger_select
        logic        ext_pol;                    // external_trigger_polarity
        logic        out_pol;                    // Signal output polarity
        logic        unlimited;                  // unlimited_sweeps
        logic [1:0]  alarm_sel;                  // Alarm number minus one
        logic [31:0] interval;                   // Sweep interval in us
        logic [15:0] total;                      // Sweeps per course
        logic [15:0] count;                      // Sweeps completed
        logic [6:0]  pre;                        // Microsecond prescaler
        logic [31:0] tmr;                        // Interval countdown
        logic [31:0] hold;                       // Scan key hold time
        logic        start_p;                    // Sweep start pulse
        logic        sig;                        // Signal output level
    } sswt_st_t;

    sswt_st_t    st;                             // Registered state
    sswt_st_t    next_st;                        // Next state
    logic [1:0]  rst_sync;                       // Reset release chain
    logic        rst_n;                          // Synchronised reset
    logic        ext_edge;                       // Qualified external edge
    logic        key_edge;                       // Scan key press
    logic [3:0]  alarm_edge;                     // Alarm onsets
    logic [31:0] ctrl_word;                      // Control register image

    // Merge a written word under byte strobes
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    // Two stages so reset leaves all flops in the same cycle
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // ------------------------------------------------------------
    // Trigger edge detection
    // ------------------------------------------------------------
    // polarity-qualified edge
    sswt_edge u_ext (
        .mclk   (mclk),
        .rst_n  (rst_n),
        .level  (ext_trigger),
        .invert (st.ext_pol),
        .pulse  (ext_edge)
    );

    // Scan key is active high
    sswt_edge u_key (
        .mclk   (mclk),
        .rst_n  (rst_n),
        .level  (scan_key),
        .invert (1'b0),
        .pulse  (key_edge)
    );

    // One detector per alarm number
    for (genvar g = 0; g < 4; g++) begin : g_alarm
        sswt_edge u_alarm (
            .mclk   (mclk),
            .rst_n  (rst_n),
            .level  (alarm_hit[g]),
            .invert (1'b0),
            .pulse  (alarm_edge[g])
        );
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic        wr_go;                      // Write performed now
        logic [31:0] wv;                         // Merged write value
        logic        start_req;                  // Course start request
        logic        stop_req;                   // Course abort request
        logic        trig;                       // Selected trigger fired
        logic        go;                         // Begin a sweep
        wr_go     = 1'b0;
        wv        = 32'h0000_0000;
        start_req = 1'b0;
        stop_req  = 1'b0;
        trig      = 1'b0;
        go        = 1'b0;
        next_st   = st;
        next_st.start_p = 1'b0;

        // Control register image for reads and merges
        ctrl_word = 32'h0000_0000;
        ctrl_word[CTRL_SEL_LSB +: 3] = st.trig_sel;
        ctrl_word[CTRL_EXT_POL]      = st.ext_pol;
        ctrl_word[CTRL_OUT_POL]      = st.out_pol;
        ctrl_word[CTRL_UNLIM]        = st.unlimited;
        ctrl_word[CTRL_ALM_LSB +: 2] = st.alarm_sel;

        // Capture address and data in either order
        if (s_axi_awvalid && s_axi_awready) begin
            next_st.aw_have = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_st.w_have = 1'b1;
            next_st.w_data = s_axi_wdata;
            next_st.w_strb = s_axi_wstrb;
        end

        // Perform the write once both halves are held
        if (st.aw_have && st.w_have && !st.bvalid) begin
            wr_go           = 1'b1;
            next_st.aw_have = 1'b0;
            next_st.w_have  = 1'b0;
            next_st.bvalid  = 1'b1;
            next_st.bresp   = RESP_OKAY;
            case ({st.aw_addr[7:2], 2'h0})
                ADDR_CTRL: begin
                    wv = merge(ctrl_word, st.w_data, st.w_strb);
                    next_st.trig_sel  = wv[CTRL_SEL_LSB +: 3];
                    next_st.ext_pol   = wv[CTRL_EXT_POL];
                    next_st.out_pol   = wv[CTRL_OUT_POL];
                    next_st.unlimited = wv[CTRL_UNLIM];
                    next_st.alarm_sel = wv[CTRL_ALM_LSB +: 2];
                    start_req = st.w_strb[1] & st.w_data[CTRL_START];
                    stop_req  = st.w_strb[1] & st.w_data[CTRL_STOP];
                end
                ADDR_INTERVAL: begin
                    next_st.interval = merge(st.interval, st.w_data, st.w_strb);
                end
                ADDR_SWEEPS: begin
                    wv = merge({16'h0000, st.total}, st.w_data, st.w_strb);
                    next_st.total = wv[15:0];
                end
                ADDR_STATUS, ADDR_COUNT: begin
                    // Read-only, write ignored
                end
                default: begin
                    next_st.bresp = RESP_SLVERR;
                end
            endcase
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end

        // Read path, answered one cycle after the address
        if (s_axi_arvalid && s_axi_arready) begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = RESP_OKAY;
            next_st.rdata  = 32'h0000_0000;
            case ({s_axi_araddr[7:2], 2'h0})
                ADDR_CTRL:     next_st.rdata = ctrl_word;
                ADDR_INTERVAL: next_st.rdata = st.interval;
                ADDR_SWEEPS:   next_st.rdata = {16'h0000, st.total};
                ADDR_STATUS: begin
                    next_st.rdata[STAT_ACTIVE] = (st.state != ST_IDLE);
                    next_st.rdata[STAT_WAIT]   = (st.state == ST_WAIT);
                    next_st.rdata[STAT_SWEEP]  = (st.state == ST_SWEEP);
                end
                ADDR_COUNT:    next_st.rdata = {16'h0000, st.count};
                default:       next_st.rresp = RESP_SLVERR;
            endcase
        end else if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end

        // Interval countdown in microseconds
        // countdown runs to zero
        if (st.pre == 7'(CYC_PER_US - 1)) begin
            next_st.pre = 7'h00;
            if (st.tmr != 32'h0000_0000) begin
                next_st.tmr = st.tmr - 32'h0000_0001;
            end
        end else begin
            next_st.pre = st.pre + 7'h01;
        end

        // Key hold time, cleared on release
        if (scan_key) begin
            if (st.hold != 32'hFFFF_FFFF) begin
                next_st.hold = st.hold + 32'h0000_0001;
            end
        end else begin
            next_st.hold = 32'h0000_0000;
        end

        // Selected trigger source
        case (st.trig_sel)
            TRIG_AUTO:     trig = 1'b1;
            TRIG_TIMER:    trig = (st.tmr == 32'h0000_0000);
            TRIG_MANUAL:   trig = key_edge;
            TRIG_EXTERNAL: trig = ext_edge;
            TRIG_ALARM:    trig = alarm_edge[st.alarm_sel];
            default:       trig = 1'b0;
        endcase

        // Sequencer
        case (st.state)
            ST_IDLE: begin
                if (start_req || key_edge) begin
                    next_st.state = ST_WAIT;
                    next_st.count = 16'h0000;
                    next_st.tmr   = st.interval;
                    next_st.pre   = 7'h00;
                end
            end
            ST_WAIT: begin
                go = trig;
            end
            ST_SWEEP: begin
                if (sweep_done) begin
                    next_st.count = st.count + 16'h0001;
                    if (!st.unlimited && (st.count + 16'h0001 >= st.total)) begin
                        next_st.state = ST_IDLE;
                    end else begin
                        next_st.state = ST_WAIT;
                    end
                end
            end
            default: begin
                next_st.state = ST_IDLE;
            end
        endcase

        // Launch a sweep and restart the interval
        if (go) begin
            next_st.state   = ST_SWEEP;
            next_st.start_p = 1'b1;
            next_st.tmr     = st.interval;
            next_st.pre     = 7'h00;
        end

        // long press ends an unlimited course
        if (st.state != ST_IDLE && st.unlimited &&
            st.hold == 32'(LONG_PRESS_CYCLES - 1) && scan_key) begin
            next_st.state   = ST_IDLE;
            next_st.start_p = 1'b0;
        end

        // Register abort wins over everything
        if (stop_req) begin
            next_st.state   = ST_IDLE;
            next_st.start_p = 1'b0;
        end

        // output active during a sweep, polarity applied
        next_st.sig = (next_st.state == ST_SWEEP) ^ next_st.out_pol;

        if (wr_go) begin
            // Nothing further; write side effects handled above
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st           <= '0;
            st.state     <= ST_IDLE;
            st.interval  <= INTERVAL_RST;
            st.total     <= SWEEPS_RST;
            st.trig_sel  <= TRIG_AUTO;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign s_axi_awready = !st.aw_have;
    assign s_axi_wready  = !st.w_have;
    assign s_axi_bvalid  = st.bvalid;
    assign s_axi_bresp   = st.bresp;
    assign s_axi_arready = !st.rvalid;
    assign s_axi_rvalid  = st.rvalid;
    assign s_axi_rdata   = st.rdata;
    assign s_axi_rresp   = st.rresp;
    assign signal_out    = st.sig;
    assign sweep_start   = st.start_p;
    assign course_active = (st.state != ST_IDLE);

endmodule

`default_nettype wire

// ==== tb/sswt_props.sv ====
// Port checker for the scan sweep trigger sequencer
`timescale 1ns/1ps
`default_nettype none

module sswt_props (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        nrst,
    // Read and write answer
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    // Sequencer
    input wire logic        sweep_start,
    input wire logic        sweep_done,
    input wire logic        signal_out,
    input wire logic        course_active
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    start_pulse_a: assert property (sweep_start |=> !sweep_start)
        else $error("sweep start longer than one cycle");
    idle_quiet_a: assert property (!course_active |=> !sweep_start)
        else $error("sweep started outside a course");
    out_follows_a: assert property (sweep_start |-> $changed(signal_out))
        else $error("signal output did not go active");
    done_ends_a: assert property (sweep_done && course_active |=> $changed(signal_out))
        else $error("signal output did not end with sweep");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read answer dropped before taken");
    r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    r_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer not released");
    b_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer not released");
endmodule

bind sswt_top sswt_props u_sswt_props (.mclk, .nrst, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready, .sweep_start,
    .sweep_done, .signal_out, .course_active);

`default_nettype wire

// ==== tb/sswt_meas.sv ====
// Measurement side model: ends each sweep after a set lag
`timescale 1ns/1ps
`default_nettype none

module sswt_meas (
    input  wire logic       mclk,
    input  wire logic       sweep_start,
    input  wire logic [7:0] lag,
    output logic            sweep_done
);
    logic [7:0] left = 8'h00;   // Cycles until the sweep ends

    always @(posedge mclk) begin
        sweep_done <= (left == 8'h01);
        if (sweep_start === 1'b1) begin
            left <= lag;
        end else if (left != 8'h00) begin
            left <= left - 8'h01;
        end
    end
    initial sweep_done = 1'b0;
endmodule

`default_nettype wire

// ==== tb/test_scan_sweep_trigger_sequencer.sv ====
// Self-checking bench of the scan sweep trigger sequencer
`timescale 1ns/1ps
`default_nettype none

module test_scan_sweep_trigger_sequencer;
    import sswt_pkg::*;
    logic        mclk, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_rready, scan_key, ext_trigger, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, signal_out, sweep_done;
    logic        sweep_start, course_active;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [3:0]  s_axi_wstrb, alarm_hit;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, lag;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    int          err_count, total_checks, cyc, n_st, t_st;

    sswt_top #(.LONG_PRESS_CYCLES(20)) u_sswt_top (.mclk, .nrst, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .scan_key, .ext_trigger, .signal_out, .alarm_hit, .sweep_done,
        .sweep_start, .course_active);
    sswt_meas u_sswt_meas (.mclk, .sweep_start, .lag, .sweep_done);

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Cycle count, sweep log and hang limit
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (sweep_start === 1'b1) begin
            n_st <= n_st + 1;
            t_st <= cyc;
        end
        if (cyc == 40000) begin
            err_count++;
            stop_test();
        end
    end

    task automatic stop_test();
        if (err_count == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic ck(input logic bad, input string m);
        total_checks++;
        if (bad) begin
            err_count++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask

    task automatic clk(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int i = 0; i < 100; i++) begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) begin
                s_axi_bready <= 1'b0;
                ck(s_axi_bresp !== e, "write response");
                return;
            end
        end
        ck(1'b1, "write hung");
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int i = 0; i < 100; i++) begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) begin
                s_axi_rready <= 1'b0;
                ck(s_axi_rdata !== d || s_axi_rresp !== e, "read data");
                return;
            end
        end
        ck(1'b1, "read hung");
    endtask

    // Count, control, then start in a separate write
    task automatic go(input logic [31:0] c, input logic [15:0] n);
        wr(ADDR_SWEEPS, {16'h0000, n}, RESP_OKAY);
        wr(ADDR_CTRL, c, RESP_OKAY);
        wr(ADDR_CTRL, c | 32'h0000_0100, RESP_OKAY);
    endtask

    task automatic wait_n(input int n);
        for (int i = 0; i < 2000 && n_st < n; i++) @(posedge mclk);
    endtask

    task automatic wait_idle();
        for (int i = 0; i < 2000 && course_active !== 1'b0; i++) @(posedge mclk);
    endtask

    task automatic press(input int h);
        @(posedge mclk);
        scan_key <= 1'b1;
        clk(h);
        scan_key <= 1'b0;
        clk(30);
    endtask

    task automatic t_regs();
        rd(ADDR_INTERVAL, INTERVAL_RST, RESP_OKAY);
        rd(ADDR_SWEEPS, {16'h0000, SWEEPS_RST}, RESP_OKAY);
        rd(8'h14, 32'h0000_0000, RESP_SLVERR);
        wr(8'h14, 32'h0000_0001, RESP_SLVERR);
    endtask

    task automatic t_auto();
        int n0 = n_st;
        go(32'h0000_0000, 16'h0003);
        wait_idle();
        clk(20);
        ck(n_st - n0 != 3, "auto sweep count");
        rd(ADDR_COUNT, 32'h0000_0003, RESP_OKAY);
    endtask

    task automatic t_timer();
        int n0 = n_st;
        int c0;
        int t1;
        wr(ADDR_INTERVAL, 32'h0000_0003, RESP_OKAY);
        go(32'h0000_0001, 16'h0002);
        c0 = cyc;
        wait_n(n0 + 1);
        ck(t_st - c0 < 195 || t_st - c0 > 405, "first timer sweep");
        t1 = t_st;
        wait_n(n0 + 2);
        ck(t_st - t1 < 200 || t_st - t1 > 405, "timer gap");
        wait_idle();
    endtask

    task automatic t_manual();
        int n0 = n_st;
        wr(ADDR_SWEEPS, 32'h0000_0002, RESP_OKAY);
        wr(ADDR_CTRL, 32'h0000_0002, RESP_OKAY);
        press(2);
        ck(course_active !== 1'b1 || n_st != n0, "key start");
        rd(ADDR_STATUS, 32'h0000_0003, RESP_OKAY);
        press(2);
        ck(n_st != n0 + 1, "manual sweep");
        press(2);
        clk(5);
        ck(n_st != n0 + 2 || course_active !== 1'b0, "manual end");
    endtask

    task automatic t_ext();
        int n0;
        for (int p = 0; p < 2; p++) begin
            n0 = n_st;
            ext_trigger <= ~p[0];
            go({27'h000_0000, p[0], p[0], 3'h3}, 16'h0001);
            ck(signal_out !== p[0], "idle output level");
            ext_trigger <= p[0];
            clk(20);
            ck(n_st != n0, "wrong edge");
            ext_trigger <= ~p[0];
            wait_n(n0 + 1);
            ck(signal_out !== ~p[0], "active output level");
            wait_idle();
            ext_trigger <= p[0];
            clk(5);
            ext_trigger <= ~p[0];
            clk(10);
            ck(n_st != n0 + 1, "trigger after end");
        end
    endtask

    task automatic t_alarm();
        int n0;
        for (int k = 0; k < 4; k++) begin
            n0 = n_st;
            go({24'h00_0000, k[1:0], 6'h04}, 16'h0001);
            alarm_hit <= 4'h1 << ((k + 1) % 4);
            clk(10);
            ck(n_st != n0, "other alarm");
            alarm_hit <= 4'h1 << k;
            wait_n(n0 + 1);
            alarm_hit <= 4'h0;
            ck(n_st != n0 + 1, "chosen alarm");
            wait_idle();
        end
    endtask

    task automatic t_unlim();
        int n0 = n_st;
        go(32'h0000_0020, 16'h0001);
        clk(200);
        press(5);
        ck(n_st - n0 < 4 || course_active !== 1'b1, "unlimited run");
        press(30);
        ck(course_active !== 1'b0, "long press stop");
        go(32'h0000_0020, 16'h0001);
        wr(ADDR_CTRL, 32'h0000_0220, RESP_OKAY);
        ck(course_active !== 1'b0, "register abort");
    endtask

    initial begin
        {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h00;
        {s_axi_rready, scan_key, ext_trigger, cyc, n_st, t_st} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, alarm_hit} = '0;
        {err_count, total_checks} = '0;
        s_axi_wstrb = 4'hF;
        lag = 8'h1E;
        clk(6);
        nrst <= 1'b1;
        clk(3);
        t_regs();
        t_auto();
        t_timer();
        t_manual();
        t_ext();
        t_alarm();
        t_unlim();
        stop_test();
    end
endmodule

`default_nettype wire
